// ===== inc/pmc_pkg.sv
// Shared constants and types for the mode and card-load controller
package pmc_pkg;

    // Clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int BLINK_HALF_MS = 250;
    localparam int STARTUP_BLINK_MS = 3000;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CYC_PER_MS;
    localparam int STARTUP_BLINK_CYC = STARTUP_BLINK_MS * CYC_PER_MS;
    localparam int CNT_W = 32;

    // APB geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DIAG_SEL = 8'h08;
    localparam logic [ADDR_W-1:0] REG_DIAG_DATA = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_DIAG_COUNT = 8'h10;
    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;

    // Control register bits
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MRES_BIT = 1;
    localparam int CTRL_COPY_BIT = 2;

    // Status register fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_OUT_INH = 2;
    localparam int ST_RUN_LED = 3;
    localparam int ST_STOP_LED = 4;
    localparam int ST_CARD_LED = 5;
    localparam int ST_FAULT = 6;
    localparam int ST_BUSY = 7;
    localparam int ST_XFER_LSB = 8;

    // Diagnostic log
    localparam int DIAG_AW = 4;
    localparam int DIAG_DW = 16;
    localparam int DIAG_DEPTH = 1 << DIAG_AW;

    // Event identifiers written after each card access
    localparam logic [DIAG_DW-1:0] EV_LOAD_RAM = 16'he101;
    localparam logic [DIAG_DW-1:0] EV_LOAD_RAM_FLASH = 16'he102;
    localparam logic [DIAG_DW-1:0] EV_LOAD_POWERON = 16'he103;
    localparam logic [DIAG_DW-1:0] EV_WRITE_CARD = 16'he104;

    // Operating modes, Gray along stop, start-up, run
    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_STARTUP = 2'b01,
        MODE_RUN = 2'b11
    } pmc_mode_t;

    // Card sequencer states
    typedef enum logic [1:0] {
        CARD_IDLE = 2'b00,
        CARD_XFER = 2'b01,
        CARD_LOG = 2'b11
    } pmc_card_t;

    // Transfer commands towards the memory subsystem
    typedef enum logic [2:0] {
        XF_NONE = 3'h0,
        XF_CARD_RAM = 3'h1,
        XF_CARD_RAM_FLASH = 3'h2,
        XF_FLASH_RAM = 3'h3,
        XF_RAM_CARD_FLASH = 3'h4
    } pmc_xfer_t;

endpackage

// ===== inc/pmc_diag_if.sv
// Diagnostic log port between controller and log memory
`timescale 1ns/1ps
`default_nettype none
interface pmc_diag_if;
    logic wr_en; // Append strobe
    logic [pmc_pkg::DIAG_AW-1:0] wr_addr; // Slot written
    logic [pmc_pkg::DIAG_DW-1:0] wr_data; // Event identifier
    logic [pmc_pkg::DIAG_AW-1:0] rd_addr; // Slot shown to software
    logic [pmc_pkg::DIAG_DW-1:0] rd_data; // Registered read data

    // Controller side
    modport writer (output wr_en, output wr_addr, output wr_data, output rd_addr,
        input rd_data);
    // Memory side
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
        output rd_data);
endinterface
`default_nettype wire

// ===== rtl/pmc_diag_mem.sv
// Small diagnostic log memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module pmc_diag_mem (
    input wire logic pclk,
    input wire logic presetn,
    pmc_diag_if.store diag
);
    import pmc_pkg::*;

    // Whole memory state
    typedef struct packed {
        logic [DIAG_DEPTH-1:0][DIAG_DW-1:0] mem;
        logic [DIAG_DW-1:0] rd_data;
    } pmc_mem_state_t;

    pmc_mem_state_t st;
    pmc_mem_state_t next_st;

    // Write slot and registered read
    always_comb
    begin
        next_st = st;
        if (diag.wr_en)
        begin
            next_st.mem[diag.wr_addr] = diag.wr_data;
        end
        next_st.rd_data = st.mem[diag.rd_addr];
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign diag.rd_data = st.rd_data;

endmodule // pmc_diag_mem
`default_nettype wire

// ===== rtl/pmc_blink_div.sv
// Blink rate divider: enable tick and square phase
`timescale 1ns/1ps
`default_nettype none
module pmc_blink_div #(
    parameter logic [pmc_pkg::CNT_W-1:0] HALF_CYCLES = pmc_pkg::CNT_W'(pmc_pkg::BLINK_HALF_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick,
    output logic phase
);
    import pmc_pkg::*;

    // Divider state
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic tick;
        logic phase;
    } pmc_div_state_t;

    pmc_div_state_t st;
    pmc_div_state_t next_st;

    // Count down, pulse and toggle at zero
    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == '0)
        begin
            next_st.cnt = HALF_CYCLES - CNT_W'(1);
            next_st.tick = 1'b1;
            next_st.phase = ~st.phase;
        end
        else
        begin
            next_st.cnt = st.cnt - CNT_W'(1);
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    assign tick = st.tick;
    assign phase = st.phase;

endmodule // pmc_blink_div
`default_nettype wire

// ===== rtl/pmc_mode_ctrl.sv
// Operating-mode sequencer and memory-card program loader
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl #(
    parameter logic [pmc_pkg::CNT_W-1:0] BLINK_HALF_CYCLES =
        pmc_pkg::CNT_W'(pmc_pkg::BLINK_HALF_CYC),
    parameter logic [pmc_pkg::CNT_W-1:0] STARTUP_BLINK_CYCLES =
        pmc_pkg::CNT_W'(pmc_pkg::STARTUP_BLINK_CYC)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmc_pkg::DATA_W-1:0] pwdata,
    input wire logic [pmc_pkg::STRB_W-1:0] pstrb,
    output logic [pmc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic startup_done,
    input wire logic startup_error,
    input wire logic cycle_overrun,
    input wire logic card_present,
    input wire logic card_has_ram_image,
    input wire logic card_has_ram_flash_image,
    input wire logic card_has_poweron_image,
    input wire logic battery_empty,
    input wire logic xfer_done,
    input wire logic user_mem_short,
    output logic output_inhibit_signal,
    output logic run_led,
    output logic stop_led,
    output logic card_activity_indicator,
    output logic system_fault_indicator,
    output logic startup_block_run,
    output logic cyclic_main_block_run,
    output logic timers_run,
    output logic clear_input_image,
    output logic clear_output_image,
    output pmc_pkg::pmc_xfer_t xfer_cmd
);
    import pmc_pkg::*;

    // Whole controller state
    typedef struct packed {
        pmc_mode_t mode; // Operating mode
        pmc_card_t card; // Card sequencer
        pmc_xfer_t xfer; // Transfer in progress
        logic run_switch; // Software run request
        logic mres_req; // Pending overall reset
        logic copy_req; // Pending copy RAM to card
        logic por_pend; // Power-on load still to check
        logic [CNT_W-1:0] hold_cnt; // Start-up blink remaining
        logic [DIAG_DW-1:0] ev_id; // Event to log
        logic [DIAG_AW-1:0] diag_sel; // Log slot shown
        logic [DIAG_AW-1:0] diag_wp; // Next log slot
        logic [DIAG_AW:0] diag_cnt; // Entries logged, saturating
        logic out_inh, run_led, stop_led, card_led, fault; // Lamps and inhibit
        logic startup_run, main_run, timers_run, clr_in, clr_out; // Program activity
        logic pready, pslverr; // Bus answer
        logic [DATA_W-1:0] prdata;
    } pmc_state_t;

    // Reset image: stop mode, outputs inhibited, power-on check pending
    localparam pmc_state_t ST_RESET = '{
        mode: MODE_STOP, card: CARD_IDLE, xfer: XF_NONE,
        run_switch: 1'b0, mres_req: 1'b0, copy_req: 1'b0, por_pend: 1'b1,
        hold_cnt: '0, ev_id: '0, diag_sel: '0, diag_wp: '0, diag_cnt: '0,
        out_inh: 1'b1, run_led: 1'b0, stop_led: 1'b1, card_led: 1'b0,
        fault: 1'b0, startup_run: 1'b0, main_run: 1'b0, timers_run: 1'b0,
        clr_in: 1'b0, clr_out: 1'b0, pready: 1'b0, pslverr: 1'b0,
        prdata: REG_RESET
    };

    pmc_state_t st;
    pmc_state_t next_st;
    logic blink_phase; // Shared lamp blink square wave
    pmc_diag_if diag ();
    // Lamp blink rate source
    pmc_blink_div #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink (
        .pclk(pclk),
        .presetn(presetn),
        .tick(),
        .phase(blink_phase)
    );
    // Diagnostic log storage
    pmc_diag_mem u_diag (
        .pclk(pclk),
        .presetn(presetn),
        .diag(diag)
    );
    // Log port driven from state
    assign diag.wr_en = (st.card == CARD_LOG);
    assign diag.wr_addr = st.diag_wp;
    assign diag.wr_data = st.ev_id;
    assign diag.rd_addr = st.diag_sel;
    // Decoded address is a defined register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_DIAG_SEL) ||
            (a == REG_DIAG_DATA) || (a == REG_DIAG_COUNT);
    endfunction
    // Transfer touches the card
    function automatic logic is_card_op(input pmc_xfer_t x);
        is_card_op = (x != XF_NONE) && (x != XF_FLASH_RAM);
    endfunction

    // Next state of mode, card sequencer, lamps and bus slave
    always_comb
    begin
        logic wr_hit; // Write completes this cycle
        logic card_busy; // Card sequencer not idle, or power-on check pending
        logic any_image; // Card holds a user program
        logic want_mres; // Software sets overall reset
        logic want_copy; // Software sets copy command
        logic take_mres; // Overall reset consumed
        logic take_copy; // Copy command consumed
        wr_hit = psel && penable && st.pready && pwrite && is_mapped(paddr);
        card_busy = (st.card != CARD_IDLE) || st.por_pend;
        any_image = card_present &&
            (card_has_ram_image || card_has_ram_flash_image || card_has_poweron_image);
        want_mres = wr_hit && (paddr == REG_CTRL) && pstrb[0] && pwdata[CTRL_MRES_BIT];
        want_copy = wr_hit && (paddr == REG_CTRL) && pstrb[0] && pwdata[CTRL_COPY_BIT];
        take_mres = 1'b0;
        take_copy = 1'b0;
        next_st = st;
        next_st.clr_in = 1'b0;
        next_st.clr_out = 1'b0;

        // Start-up blink hold counts down to zero
        if (st.hold_cnt != '0)
            next_st.hold_cnt = st.hold_cnt - CNT_W'(1);

        // Operating mode sequence
        unique case (st.mode)
            MODE_STOP:
                // Nothing is cleared on entry to stop, state stays as left
                if (st.run_switch && !card_busy)
                begin
                    next_st.mode = MODE_STARTUP;
                    next_st.clr_in = 1'b1;
                    next_st.hold_cnt = STARTUP_BLINK_CYCLES;
                end
            MODE_STARTUP:
                // Overrun ignored here: start-up is not time supervised
                if (startup_error || !st.run_switch)
                    next_st.mode = MODE_STOP;
                else if (startup_done)
                begin
                    next_st.mode = MODE_RUN;
                    next_st.clr_out = 1'b1;
                end
            MODE_RUN:
                // Cycle overrun, error or switch drop stop the program
                if (startup_error || cycle_overrun || !st.run_switch)
                    next_st.mode = MODE_STOP;
            default:
                // Illegal code falls back to the safe mode
                next_st.mode = MODE_STOP;
        endcase

        // Card load and write sequencer
        unique case (st.card)
            CARD_IDLE:
            begin
                if (st.por_pend)
                begin
                    // Power-on: card power-on image, else flash if battery empty and no card image
                    next_st.por_pend = 1'b0;
                    if (card_present && card_has_poweron_image)
                    begin
                        next_st.xfer = XF_CARD_RAM;
                        next_st.ev_id = EV_LOAD_POWERON;
                        next_st.card = CARD_XFER;
                    end
                    else if (battery_empty && !any_image)
                    begin
                        next_st.xfer = XF_FLASH_RAM;
                        next_st.card = CARD_XFER;
                    end
                end
                else if (st.mres_req && (st.mode == MODE_STOP))
                begin
                    // Overall reset: flash variant takes precedence
                    take_mres = 1'b1;
                    next_st.fault = 1'b0;
                    if (card_present && card_has_ram_flash_image)
                    begin
                        next_st.xfer = XF_CARD_RAM_FLASH;
                        next_st.ev_id = EV_LOAD_RAM_FLASH;
                        next_st.card = CARD_XFER;
                    end
                    else if (card_present && card_has_ram_image)
                    begin
                        next_st.xfer = XF_CARD_RAM;
                        next_st.ev_id = EV_LOAD_RAM;
                        next_st.card = CARD_XFER;
                    end
                    else if (battery_empty && !any_image)
                    begin
                        next_st.xfer = XF_FLASH_RAM;
                        next_st.card = CARD_XFER;
                    end
                end
                else if (st.copy_req)
                begin
                    // Copy without a card is dropped
                    take_copy = 1'b1;
                    if (card_present)
                    begin
                        next_st.xfer = XF_RAM_CARD_FLASH;
                        next_st.ev_id = EV_WRITE_CARD;
                        next_st.card = CARD_XFER;
                    end
                end
            end
            CARD_XFER:
            begin
                // Short memory leaves a partial load, flagged by the lamp
                if (user_mem_short && (st.xfer != XF_RAM_CARD_FLASH))
                    next_st.fault = 1'b1;
                if (xfer_done)
                begin
                    next_st.xfer = XF_NONE;
                    next_st.card = is_card_op(st.xfer) ? CARD_LOG : CARD_IDLE;
                end
            end
            CARD_LOG:
            begin
                // One entry appended per card access
                next_st.diag_wp = st.diag_wp + DIAG_AW'(1);
                if (st.diag_cnt != (DIAG_AW+1)'(DIAG_DEPTH))
                    next_st.diag_cnt = st.diag_cnt + (DIAG_AW+1)'(1);
                next_st.card = CARD_IDLE;
            end
            default:
                next_st.card = CARD_IDLE;
        endcase

        // Command bits: a new request wins over consumption
        next_st.mres_req = (st.mres_req && !take_mres) || want_mres;
        next_st.copy_req = (st.copy_req && !take_copy) || want_copy;

        // Register writes at the completing edge
        if (wr_hit && pstrb[0])
        begin
            if (paddr == REG_CTRL)
                next_st.run_switch = pwdata[CTRL_RUN_BIT];
            else if (paddr == REG_DIAG_SEL)
                next_st.diag_sel = pwdata[DIAG_AW-1:0];
        end

        // Inhibit held outside run, released only in run
        next_st.out_inh = (next_st.mode != MODE_RUN);
        // Program activity follows the mode
        next_st.startup_run = (next_st.mode == MODE_STARTUP);
        next_st.main_run = (next_st.mode == MODE_RUN);
        next_st.timers_run = (next_st.mode == MODE_RUN);
        // Run lamp blinks through start-up and the minimum hold
        if ((next_st.mode == MODE_STARTUP) || (next_st.hold_cnt != '0))
            next_st.run_led = blink_phase;
        else
            next_st.run_led = (next_st.mode == MODE_RUN);
        next_st.stop_led = (next_st.mode == MODE_STOP);
        // Card lamp blinks while card or flash transfer runs
        next_st.card_led = (next_st.card == CARD_XFER) && blink_phase;

        // APB: one wait state, then ready with data or error
        if (psel && penable && !st.pready)
        begin
            next_st.pready = 1'b1;
            next_st.pslverr = !is_mapped(paddr);
            next_st.prdata = REG_RESET;
            if (!pwrite)
            begin
                unique case (paddr)
                    REG_CTRL:
                    begin
                        next_st.prdata[CTRL_RUN_BIT] = st.run_switch;
                        next_st.prdata[CTRL_MRES_BIT] = st.mres_req;
                        next_st.prdata[CTRL_COPY_BIT] = st.copy_req;
                    end
                    REG_STATUS:
                    begin
                        next_st.prdata[ST_MODE_LSB +: 2] = st.mode;
                        next_st.prdata[ST_OUT_INH] = st.out_inh;
                        next_st.prdata[ST_RUN_LED] = st.run_led;
                        next_st.prdata[ST_STOP_LED] = st.stop_led;
                        next_st.prdata[ST_CARD_LED] = st.card_led;
                        next_st.prdata[ST_FAULT] = st.fault;
                        next_st.prdata[ST_BUSY] = card_busy;
                        next_st.prdata[ST_XFER_LSB +: 3] = st.xfer;
                    end
                    REG_DIAG_SEL:
                        next_st.prdata[DIAG_AW-1:0] = st.diag_sel;
                    REG_DIAG_DATA:
                        next_st.prdata[DIAG_DW-1:0] = diag.rd_data;
                    REG_DIAG_COUNT:
                        next_st.prdata[DIAG_AW:0] = st.diag_cnt;
                    default:
                        // Unmapped reads return zero with error
                        next_st.prdata = REG_RESET;
                endcase
            end
        end
        else
        begin
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    // Outputs straight from the state register
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign output_inhibit_signal = st.out_inh;
    assign run_led = st.run_led;
    assign stop_led = st.stop_led;
    assign card_activity_indicator = st.card_led;
    assign system_fault_indicator = st.fault;
    assign startup_block_run = st.startup_run;
    assign cyclic_main_block_run = st.main_run;
    assign timers_run = st.timers_run;
    assign clear_input_image = st.clr_in;
    assign clear_output_image = st.clr_out;
    assign xfer_cmd = st.xfer;

endmodule // pmc_mode_ctrl
`default_nettype wire

// ===== verif/pmc_card_model.sv
// Memory-card side model: ends each transfer after a set latency
`timescale 1ns/1ps
`default_nettype none
module pmc_card_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire pmc_pkg::pmc_xfer_t xfer_cmd,
    input wire logic [7:0] lat,
    output logic xfer_done
);
    import pmc_pkg::*;
    logic [7:0] cnt; // Cycles spent on this transfer
    // One-cycle completion pulse once the latency has run out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 8'h0;
            xfer_done <= 1'b0;
        end
        else if (xfer_done || xfer_cmd == XF_NONE)
        begin
            cnt <= 8'h0;
            xfer_done <= 1'b0;
        end
        else
        begin
            cnt <= cnt + 8'h1;
            xfer_done <= (cnt == lat);
        end
    end
endmodule // pmc_card_model
`default_nettype wire

// ===== verif/pmc_mode_chk.sv
// Port-level assertions for the mode and card-load controller
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic startup_done,
    input wire logic startup_error,
    input wire logic xfer_done,
    input wire logic output_inhibit_signal,
    input wire logic stop_led,
    input wire logic card_activity_indicator,
    input wire logic startup_block_run,
    input wire logic cyclic_main_block_run,
    input wire logic timers_run,
    input wire logic clear_input_image,
    input wire logic clear_output_image,
    input wire pmc_pkg::pmc_xfer_t xfer_cmd
);
    import pmc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_STOP: assert property (stop_led |-> output_inhibit_signal && !cyclic_main_block_run)
        else $error("stop without inhibit");
    AST_SU: assert property (startup_block_run |-> output_inhibit_signal && !stop_led)
        else $error("start-up outputs wrong");
    AST_RUN: assert property (cyclic_main_block_run |-> !output_inhibit_signal && timers_run)
        else $error("run outputs wrong");
    AST_VIA_SU: assert property ($rose(cyclic_main_block_run) |-> $past(startup_block_run))
        else $error("run without start-up");
    AST_DONE: assert property (startup_block_run && startup_done && !startup_error |=> cyclic_main_block_run)
        else $error("no run after start-up");
    AST_CLR_IN: assert property ($rose(startup_block_run) |-> clear_input_image ##1 !clear_input_image)
        else $error("input clear pulse wrong");
    AST_CLR_OUT: assert property ($rose(cyclic_main_block_run) |-> clear_output_image ##1 !clear_output_image)
        else $error("output clear pulse wrong");
    AST_LAMP: assert property (xfer_cmd == XF_NONE |-> !card_activity_indicator)
        else $error("card lamp on while idle");
    AST_HOLD: assert property (xfer_cmd != XF_NONE && !xfer_done |=> xfer_cmd == $past(xfer_cmd))
        else $error("transfer dropped early");
endmodule // pmc_mode_chk
bind pmc_mode_ctrl pmc_mode_chk pmc_mode_chk_i (.pclk, .presetn, .startup_done, .startup_error,
    .xfer_done, .output_inhibit_signal, .stop_led, .card_activity_indicator, .startup_block_run,
    .cyclic_main_block_run, .timers_run, .clear_input_image, .clear_output_image, .xfer_cmd);
`default_nettype wire

// ===== verif/pmc_mode_ctrl_tb_top.sv
// Self-checking bench for the mode and card-load controller
`timescale 1ns/1ps
`default_nettype none
module pmc_mode_ctrl_tb_top;
    import pmc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0, lat = 8'h1e;
    logic [31:0] pwdata = 32'h0, prdata;
    logic startup_done = 1'b0, card_present = 1'b1, card_has_ram_image = 1'b0;
    logic card_has_ram_flash_image = 1'b0, battery_empty = 1'b0, user_mem_short = 1'b0;
    logic card_has_poweron_image = 1'b1, cycle_overrun = 1'b0; // Far-side flags
    logic pready, pslverr, xfer_done;
    localparam int HOST_BAUD = 38400; // host serial link, outside this block
    pmc_xfer_t xfer_cmd;
    logic [64:0] q[$]; // Expected {error, mask, data} per read
    int miscompares = 0, n_checks = 0, nlog = 0;
    // Row table: command, card flags, transfer, event id
    logic [31:0] ct [5] = '{32'h0, 32'h2, 32'h2, 32'h4, 32'h2};
    logic [3:0] fl [5] = '{4'h8, 4'he, 4'hc, 4'hc, 4'h1};
    pmc_xfer_t xp [5] = '{XF_CARD_RAM, XF_CARD_RAM_FLASH, XF_CARD_RAM, XF_RAM_CARD_FLASH, XF_FLASH_RAM};
    logic [15:0] ev [5] = '{EV_LOAD_POWERON, EV_LOAD_RAM_FLASH, EV_LOAD_RAM, EV_WRITE_CARD, 16'h0};
    always #5 pclk = ~pclk;
    pmc_mode_ctrl #(.BLINK_HALF_CYCLES(32'h4), .STARTUP_BLINK_CYCLES(32'h28)) pmc_mode_ctrl_i (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hf), .prdata,
        .pready, .pslverr, .startup_done, .startup_error(1'b0), .cycle_overrun,
        .card_present, .card_has_ram_image, .card_has_ram_flash_image,
        .card_has_poweron_image, .battery_empty, .xfer_done, .user_mem_short,
        .output_inhibit_signal(), .run_led(), .stop_led(), .card_activity_indicator(),
        .system_fault_indicator(), .startup_block_run(), .cyclic_main_block_run(),
        .timers_run(), .clear_input_image(), .clear_output_image(), .xfer_cmd);
    pmc_card_model pmc_card_model_i (.pclk, .presetn, .xfer_cmd, .lat, .xfer_done);
    task automatic wrap_up;
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, penable, paddr, pwrite, pwdata} <= {2'b10, a, w, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
        {psel, penable} <= 2'b00;
        if (n >= 50)
        begin
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, logic se);
        q.push_back({se, m, e});
        apb(a, 1'b0, 32'h0);
    endtask
    // Compare each read answer against the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
        begin
            n_checks++;
            if (((prdata ^ q[0][31:0]) & q[0][63:32]) !== 32'h0 || pslverr !== q[0][64])
            begin
                miscompares++;
                $display("ERROR %0t got %h exp %h", $time, {pslverr, prdata}, q[0]);
            end
            void'(q.pop_front());
        end
    end
    initial
    begin
        void'($urandom(32'h68a3b267));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            lat <= 8'($urandom_range(20, 40));
            {card_present, card_has_ram_image, card_has_ram_flash_image, battery_empty} <= fl[i];
            user_mem_short <= (i == 1);
            card_has_poweron_image <= (i == 0);
            if (ct[i] != 32'h0)
                apb(REG_CTRL, 1'b1, ct[i]);
            rd(REG_STATUS, 32'h700, 32'(xp[i]) << 8, 1'b0);
            for (int n = 0; xfer_cmd !== XF_NONE; n++)
            begin
                @(posedge pclk);
                if (n > 200)
                begin
                    miscompares++;
                    wrap_up();
                end
            end
            repeat (3) @(posedge pclk);
            rd(REG_STATUS, 32'h40, 32'(i == 1) << 6, 1'b0);
            if (ev[i] != 16'h0)
            begin
                apb(REG_DIAG_SEL, 1'b1, 32'(nlog));
                rd(REG_DIAG_DATA, 32'hffff, 32'(ev[i]), 1'b0);
                nlog++;
            end
        end
        rd(REG_DIAG_COUNT, 32'h1f, 32'(nlog), 1'b0);
        apb(REG_CTRL, 1'b1, 32'h1);
        cycle_overrun <= 1'b1;
        rd(REG_STATUS, 32'h17, 32'h5, 1'b0);
        {startup_done, cycle_overrun} <= 2'b10;
        rd(REG_STATUS, 32'h17, 32'h3, 1'b0);
        startup_done <= 1'b0;
        repeat (50) @(posedge pclk);
        rd(REG_STATUS, 32'h1f, 32'hb, 1'b0);
        apb(REG_CTRL, 1'b1, 32'h0);
        rd(REG_STATUS, 32'h17, 32'h14, 1'b0);
        rd(8'h14, 32'h0, 32'h0, 1'b1);
        wrap_up();
    end
endmodule // pmc_mode_ctrl_tb_top
`default_nettype wire
